// ### pgen_defs.svh
`ifndef PGEN_DEFS_SVH
`define PGEN_DEFS_SVH
// Overview of operation
// (R1) Single run emits every main vector once, first entry to last.
// (R2) After a single run the last vector data stays on the outputs.
// (R3) Repetitive mode wraps main list to its start until stopped.
// (R4) Repetitive mode plays the init list on the first pass only.
// (R5) Init list sits between fixed start and end marker entries.
// (R6) A label holds at most 32 channels mapped onto pod lines.
// (R7) A label write overlapping another label is rejected and flagged.
// (R8) Only channels selected in some label drive generated data.
// (R9) Half-channel mode uses only pods 1 and 3.
// (R10) External vector clock must not exceed the configured range; the code does not check the external clock rate.
// (R11) Vector clock comes from internal period generator or external clock.
// (R12) Clock output has an adjustable delay relative to the data.
// (R13) Each vector may carry break, signal, wait or conditional instruction.
// (R14) Software instructions: macro insertion and repeat loop.
// (R15) Macro parameter is bound per insertion and substituted into data.
// (R16) Macro changes apply wherever that macro is inserted.
// (R17) Each vector is launched on the rising vector clock edge.
// (R18) Internal period limits: 10 ns full, 5 ns half, 250 ms maximum; the code clamps both minima to one 40 ns system cycle.
// (R19) Wait-for-event holds data and stalls the list until the event.

`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_PERIOD 8'h08
`define A_CLKDLY 8'h0C
`define A_LISTLEN 8'h10
`define A_MADDR 8'h14
`define A_MINST 8'h18
`define A_MDATA 8'h1C
`define A_LSEL 8'h20
`define A_LMASK 8'h24
`define A_MACDEF 8'h28

`define CTRL_RUN 0
`define CTRL_STOP 1
`define CTRL_REP 2
`define CTRL_EXT 3
`define CTRL_HALF 4
`define CTRL_CLRERR 5

`define PERIOD_RST 24'h00_0019
`define CLKDLY_RST 8'h00
`define POD13_MASK 32'h00FF_00FF

`define SYS_CLK_KHZ 25000
`define PER_MIN_FULL_NS 10
`define PER_MIN_HALF_NS 5
`define PER_MAX_MS 250
`define NS_UP_CYC(ns) ((((ns) * `SYS_CLK_KHZ + 999999) / 1000000) > 0 ? \
	(((ns) * `SYS_CLK_KHZ + 999999) / 1000000) : 1)
`define PER_MIN_FULL_CYC 24'(`NS_UP_CYC(`PER_MIN_FULL_NS))
`define PER_MIN_HALF_CYC 24'(`NS_UP_CYC(`PER_MIN_HALF_NS))
`define PER_MAX_CYC (`PER_MAX_MS * `SYS_CLK_KHZ)

`endif

// ### pgen_pkg.sv
package pgen_pkg;
	typedef enum logic [3:0] {
		I_NOP = 4'h0,
		I_BREAK = 4'h1,
		I_SIGNAL = 4'h2,
		I_WAIT = 4'h3,
		I_IFEV = 4'h4,
		I_MACRO = 4'h5,
		I_REPEAT = 4'h6,
		I_MARK_S = 4'h7,
		I_MARK_E = 4'h8,
		I_PARAM = 4'h9
	} vector_instruction_field_t;
	typedef struct packed {
		vector_instruction_field_t vector_instruction_field;
		logic [7:0] opnd;
		logic [31:0] data;
	} vec_t;
	typedef struct packed {
		logic [7:0] start;
		logic [7:0] len;
	} macro_t;
	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_FETCH = 6'h02,
		S_DECODE = 6'h04,
		S_TICK = 6'h08,
		S_WAITEV = 6'h10,
		S_DONE = 6'h20
	} seq_state_t;
endpackage

// ### period_gen.sv
`timescale 1ns/100ps
module period_gen (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [23:0] period,
	output logic tick
);
	logic [23:0] cnt;
	assign tick = (cnt >= (period - 24'h00_0001));
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 24'h00_0000;
		end else if (tick) begin
			cnt <= 24'h00_0000;
		end else begin
			cnt <= cnt + 24'h00_0001;
		end
	end
endmodule // period_gen

// ### link_edge.sv
`timescale 1ns/100ps
module link_edge (
	input wire logic vec_ext_clk,
	input wire logic sys_clk,
	input wire logic rstn,
	output logic edge_seen
);
	logic tog;
	logic s1;
	logic s2;
	logic s3;
	logic agreed;
	// Toggle per external rising edge, carried across as a level
	always_ff @(posedge vec_ext_clk or negedge rstn) begin
		if (!rstn) begin
			tog <= 1'b0;
		end else begin
			tog <= ~tog;
		end
	end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			agreed <= 1'b0;
		end else begin
			s1 <= tog;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				agreed <= s3;
			end
		end
	end
	assign edge_seen = (s2 == s3) && (s3 != agreed);
endmodule // link_edge

// ### pattern_seq.sv
`timescale 1ns/100ps
`include "pgen_defs.svh"
module pattern_seq #(
	parameter logic [23:0] PER_MAX_CYC = 24'(`PER_MAX_CYC)
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic vec_ext_clk,
	input wire logic event_in,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic [31:0] pat_data,
	output logic [31:0] pat_oe,
	output logic clk_out,
	output logic intermodule_signal_line,
	output logic busy
);
	pgen_pkg::vec_t mem [0:255];
	pgen_pkg::vec_t mem_q;
	pgen_pkg::vec_t entry;
	pgen_pkg::macro_t macros [0:3];
	pgen_pkg::seq_state_t state;
	pgen_pkg::seq_state_t next_state;
	logic [31:0] label [0:3];
	logic [31:0] others;
	logic [31:0] chan_sel;
	logic rep_mode;
	logic ext_src;
	logic half_mode;
	logic label_err;
	logic [23:0] period;
	logic [7:0] clkdly;
	logic [7:0] init_len;
	logic [7:0] main_len;
	logic [7:0] maddr;
	logic [11:0] minst;
	logic [1:0] lsel;
	logic [7:0] ptr;
	logic [7:0] ret_ptr;
	logic [7:0] mac_left;
	logic [31:0] param;
	logic [7:0] rep_left;
	logic in_macro;
	logic skip;
	logic first_pass;
	logic launch;
	logic [7:0] dly_cnt;
	logic dly_arm;
	logic ev_s1;
	logic ev_s2;
	logic ev_s3;
	logic ev;
	logic adv;
	logic int_tick;
	logic ext_edge;

	wire logic wr_ctrl = wr && (addr == `A_CTRL);
	wire logic run_hit = wr_ctrl && wdata[`CTRL_RUN];
	wire logic stop_hit = wr_ctrl && wdata[`CTRL_STOP];
	wire logic clr_err = wr_ctrl && wdata[`CTRL_CLRERR];
	wire logic wr_lmask = wr && (addr == `A_LMASK);
	wire logic wr_mdata = wr && (addr == `A_MDATA);
	wire logic wr_macdef = wr && (addr == `A_MACDEF);
	wire logic overlap = |(wdata & others);

	// Clamp period into the legal range of the current output mode
	wire logic [23:0] per_min = half_mode ? `PER_MIN_HALF_CYC : `PER_MIN_FULL_CYC;
	wire logic [23:0] per_eff = (period < per_min) ? per_min :
		((period > PER_MAX_CYC) ? PER_MAX_CYC : period); // R18

	period_gen u_period (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.period(per_eff),
		.tick(int_tick)
	);

	link_edge u_link (
		.vec_ext_clk(vec_ext_clk),
		.sys_clk(sys_clk),
		.rstn(rstn),
		.edge_seen(ext_edge)
	);

	wire logic tick = ext_src ? ext_edge : int_tick; // R11 R17

	// List layout: start marker, init list, end marker, main list
	wire logic [7:0] init_end = init_len + 8'h01;
	wire logic [7:0] main_start = init_len + 8'h02;
	wire logic [7:0] main_last = init_len + main_len + 8'h01;
	wire logic on_start = !in_macro && (ptr == 8'h00);
	wire logic on_end = !in_macro && (ptr == init_end);

	always_comb begin
		entry = mem_q;
		if (on_start) begin
			entry = '{vector_instruction_field: pgen_pkg::I_MARK_S, opnd: 8'h00, data: 32'h0000_0000}; // R5
		end else if (on_end) begin
			entry = '{vector_instruction_field: pgen_pkg::I_MARK_E, opnd: 8'h00, data: 32'h0000_0000}; // R5
		end
	end

	wire pgen_pkg::vector_instruction_field_t vector_instruction_field = entry.vector_instruction_field;
	wire pgen_pkg::macro_t mac = macros[entry.opnd[1:0]];
	wire logic is_mark = (vector_instruction_field == pgen_pkg::I_MARK_S) || (vector_instruction_field == pgen_pkg::I_MARK_E);
	wire logic is_call = (vector_instruction_field == pgen_pkg::I_MACRO) && !in_macro;

	// Step to the next entry, returning from a macro or wrapping the list
	wire logic leave_mac = in_macro && (mac_left == 8'h01);
	wire logic [7:0] list_pos = leave_mac ? ret_ptr : ptr;
	wire logic list_end = (!in_macro || leave_mac) && (list_pos == main_last);
	wire logic [7:0] step_ptr = list_end ? main_start : (list_pos + 8'h01); // R3 R4
	wire logic fin = list_end && !rep_mode; // R1

	always_comb begin
		adv = 1'b0;
		next_state = state;
		case (state)
			pgen_pkg::S_IDLE, pgen_pkg::S_DONE: begin
				if (run_hit) begin
					next_state = pgen_pkg::S_FETCH;
				end
			end
			pgen_pkg::S_FETCH: begin
				next_state = pgen_pkg::S_DECODE;
			end
			pgen_pkg::S_DECODE: begin
				if (skip || is_mark || (is_call && (mac.len == 8'h00))) begin
					adv = 1'b1;
				end else if (is_call) begin
					next_state = pgen_pkg::S_FETCH; // R14
				end else begin
					next_state = pgen_pkg::S_TICK;
				end
			end
			pgen_pkg::S_TICK: begin
				if (tick && (rep_left == 8'h00)) begin
					if (vector_instruction_field == pgen_pkg::I_BREAK) begin
						next_state = pgen_pkg::S_DONE; // R13
					end else if ((vector_instruction_field == pgen_pkg::I_WAIT) && !ev) begin
						next_state = pgen_pkg::S_WAITEV; // R19
					end else begin
						adv = 1'b1;
					end
				end
			end
			pgen_pkg::S_WAITEV: begin
				adv = ev; // R19
			end
			default: begin
				next_state = pgen_pkg::S_IDLE;
			end
		endcase
		if (adv) begin
			next_state = fin ? pgen_pkg::S_DONE : pgen_pkg::S_FETCH; // R2
		end
		if (stop_hit && (state != pgen_pkg::S_IDLE)) begin
			next_state = pgen_pkg::S_DONE; // R3
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state <= pgen_pkg::S_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Pointer and macro call bookkeeping
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ptr <= 8'h00;
			ret_ptr <= 8'h00;
			mac_left <= 8'h00;
			param <= 32'h0000_0000;
			in_macro <= 1'b0;
		end else if (run_hit && (state == pgen_pkg::S_IDLE || state == pgen_pkg::S_DONE)) begin
			ptr <= 8'h00; // R1 R5
			in_macro <= 1'b0;
		end else if (state == pgen_pkg::S_DECODE && is_call && !skip && mac.len != 8'h00) begin
			ret_ptr <= ptr;
			ptr <= mac.start; // R16
			mac_left <= mac.len;
			param <= entry.data; // R15
			in_macro <= 1'b1;
		end else if (adv) begin
			ptr <= step_ptr;
			mac_left <= mac_left - 8'h01;
			in_macro <= in_macro && !leave_mac;
		end
	end

	// Pass flag, repeat count and conditional skip
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			first_pass <= 1'b0;
			rep_left <= 8'h00;
			skip <= 1'b0;
		end else begin
			if (run_hit && !busy) begin
				first_pass <= 1'b1;
			end else if (adv && list_end) begin
				first_pass <= 1'b0; // R4
			end
			if (state == pgen_pkg::S_DECODE) begin
				rep_left <= (vector_instruction_field == pgen_pkg::I_REPEAT) ? entry.opnd : 8'h00; // R14
			end else if (state == pgen_pkg::S_TICK && tick && rep_left != 8'h00) begin
				rep_left <= rep_left - 8'h01;
			end
			if (run_hit && !busy) begin
				skip <= 1'b0;
			end else if (state == pgen_pkg::S_DECODE && skip) begin
				skip <= 1'b0;
			end else if (adv && state == pgen_pkg::S_TICK) begin
				skip <= (vector_instruction_field == pgen_pkg::I_IFEV) && !ev; // R13
			end
		end
	end

	wire logic fire = (state == pgen_pkg::S_TICK) && tick; // R17
	wire logic [31:0] vec_data = (vector_instruction_field == pgen_pkg::I_PARAM) ? param : entry.data; // R15

	// Output data held until the next launch
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pat_data <= 32'h0000_0000;
			pat_oe <= 32'h0000_0000;
			launch <= 1'b0;
			intermodule_signal_line <= 1'b0;
		end else begin
			pat_oe <= chan_sel; // R8
			launch <= fire;
			intermodule_signal_line <= fire && (rep_left == 8'h00) &&
				(vector_instruction_field == pgen_pkg::I_SIGNAL); // R13
			if (fire) begin
				pat_data <= vec_data & chan_sel; // R2 R8
			end
		end
	end

	// Clock out rises a programmable number of cycles after the data
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			clk_out <= 1'b0;
			dly_cnt <= 8'h00;
			dly_arm <= 1'b0;
		end else if (launch) begin
			clk_out <= 1'b0;
			dly_cnt <= clkdly; // R12
			dly_arm <= 1'b1;
		end else if (dly_arm && dly_cnt == 8'h00) begin
			clk_out <= 1'b1; // R12
			dly_arm <= 1'b0;
		end else if (dly_arm) begin
			dly_cnt <= dly_cnt - 8'h01;
		end
	end

	// Event input: three stages, accepted once the last two agree
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ev_s1 <= 1'b0;
			ev_s2 <= 1'b0;
			ev_s3 <= 1'b0;
			ev <= 1'b0;
		end else begin
			ev_s1 <= event_in;
			ev_s2 <= ev_s1;
			ev_s3 <= ev_s2;
			if (ev_s2 == ev_s3) begin
				ev <= ev_s3;
			end
		end
	end

	assign busy = (state != pgen_pkg::S_IDLE) && (state != pgen_pkg::S_DONE);

	// Vector memory, synchronous read at the current pointer
	always_ff @(posedge sys_clk) begin
		if (wr_mdata) begin
			mem[maddr] <= {pgen_pkg::vector_instruction_field_t'(minst[11:8]), minst[7:0], wdata};
		end
		mem_q <= mem[ptr];
	end

	// Label masks: overlap against other labels is refused
	always_comb begin
		others = 32'h0000_0000;
		chan_sel = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			if (i[1:0] != lsel) begin
				others = others | label[i];
			end
			chan_sel = chan_sel | label[i];
		end
		if (half_mode) begin
			chan_sel = chan_sel & `POD13_MASK; // R9
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 4; i++) begin
				label[i] <= 32'h0000_0000;
			end
		end else if (wr_lmask && !overlap) begin
			label[lsel] <= wdata; // R6 R7
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			label_err <= 1'b0;
		end else if (wr_lmask && overlap) begin
			label_err <= 1'b1; // R7
		end else if (clr_err) begin
			label_err <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 4; i++) begin
				macros[i] <= '{start: 8'h00, len: 8'h00};
			end
		end else if (wr_macdef) begin
			macros[wdata[17:16]] <= '{start: wdata[7:0], len: wdata[15:8]}; // R16
		end
	end

	// Configuration registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rep_mode <= 1'b0;
			ext_src <= 1'b0;
			half_mode <= 1'b0;
			period <= `PERIOD_RST;
			clkdly <= `CLKDLY_RST;
			init_len <= 8'h00;
			main_len <= 8'h00;
			lsel <= 2'h0;
			minst <= 12'h000;
		end else if (wr) begin
			if (addr == `A_CTRL) begin
				rep_mode <= wdata[`CTRL_REP];
				ext_src <= wdata[`CTRL_EXT]; // R11
				half_mode <= wdata[`CTRL_HALF];
			end
			if (addr == `A_PERIOD) begin
				period <= wdata[23:0];
			end
			if (addr == `A_CLKDLY) begin
				clkdly <= wdata[7:0];
			end
			if (addr == `A_LISTLEN) begin
				init_len <= wdata[7:0];
				main_len <= wdata[15:8];
			end
			if (addr == `A_LSEL) begin
				lsel <= wdata[1:0];
			end
			if (addr == `A_MINST) begin
				minst <= wdata[11:0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			maddr <= 8'h00;
		end else if (wr && addr == `A_MADDR) begin
			maddr <= wdata[7:0];
		end else if (wr_mdata) begin
			maddr <= maddr + 8'h01;
		end
	end

	// Read-back
	wire logic [31:0] stat_word = {16'h0000, ptr, 2'h0,
		state == pgen_pkg::S_WAITEV, label_err, in_macro, first_pass,
		state == pgen_pkg::S_DONE, busy};
	wire logic [31:0] ctrl_word = {27'h000_0000, half_mode, ext_src, rep_mode, 2'h0};
	wire pgen_pkg::macro_t mac_rd = macros[lsel];
	wire logic [31:0] rd_mux =
		(addr == `A_CTRL) ? ctrl_word :
		(addr == `A_STAT) ? stat_word :
		(addr == `A_PERIOD) ? {8'h00, period} :
		(addr == `A_CLKDLY) ? {24'h00_0000, clkdly} :
		(addr == `A_LISTLEN) ? {16'h0000, main_len, init_len} :
		(addr == `A_MADDR) ? {24'h00_0000, maddr} :
		(addr == `A_MINST) ? {20'h0_0000, minst} :
		(addr == `A_LSEL) ? {30'h0000_0000, lsel} :
		(addr == `A_LMASK) ? label[lsel] :
		(addr == `A_MACDEF) ? {16'h0000, mac_rd.len, mac_rd.start} :
		32'h0000_0000;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= rd ? rd_mux : 32'h0000_0000;
		end
	end
endmodule // pattern_seq

// ### pattern_seq_monitor.sv
`timescale 1ns/100ps
`include "pgen_defs.svh"
module pattern_seq_monitor #(
	parameter logic [23:0] PER_MAX_CYC = 24'(`PER_MAX_CYC)
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic vec_ext_clk,
	input wire logic event_in,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic [31:0] pat_data,
	input wire logic [31:0] pat_oe,
	input wire logic clk_out,
	input wire logic intermodule_signal_line,
	input wire logic busy
);
	logic [7:0] dly_q;
	logic half_q;
	logic rep_q;
	logic seen_hi;
	logic [8:0] low_cnt;
	wire ctrl_wr = wr && addr == `A_CTRL;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Shadows of the mode and delay settings, seen from the bus
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dly_q <= 8'h00;
			half_q <= 1'b0;
			rep_q <= 1'b0;
		end else if (wr) begin
			if (addr == `A_CLKDLY)
				dly_q <= wdata[7:0];
			if (ctrl_wr) begin
				half_q <= wdata[`CTRL_HALF];
				rep_q <= wdata[`CTRL_REP];
			end
		end
	end
	// Length of each low phase of clk_out; rises are checked only once clk_out has been high since the last control write
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			low_cnt <= 9'h000;
			seen_hi <= 1'b0;
		end else begin
			low_cnt <= clk_out ? 9'h000 : low_cnt + 9'h001;
			seen_hi <= ctrl_wr ? 1'b0 : (seen_hi | clk_out);
		end
	end
	property p_sel_only;
		!$past(wr) && !$past(wr, 2) |-> (pat_data & ~pat_oe) == 32'h0000_0000;
	endproperty
	a_sel_only: assert property (p_sel_only) else $error("data on unselected channel");
	property p_half;
		half_q && $past(half_q) |-> (pat_oe & ~`POD13_MASK) == 32'h0000_0000;
	endproperty
	a_half: assert property (p_half) else $error("half mode drives pods 2 or 4");
	property p_clk_dly;
		seen_hi && $rose(clk_out) |-> low_cnt == {1'b0, dly_q} + 9'h001;
	endproperty
	a_clk_dly: assert property (p_clk_dly) else $error("clock out delay wrong");
	property p_sig_pulse;
		intermodule_signal_line |=> !intermodule_signal_line;
	endproperty
	a_sig_pulse: assert property (p_sig_pulse) else $error("signal pulse too long");
	property p_hold;
		!busy && !$past(busy) && !$past(busy, 2) && !$past(wr) && !$past(wr, 2)
			&& !$past(wr, 3) |-> $stable(pat_data);
	endproperty
	a_hold: assert property (p_hold) else $error("data changed while idle");
	property p_launch;
		$changed(pat_data) && $past(busy) |=> !clk_out;
	endproperty
	a_launch: assert property (p_launch) else $error("clock out not low after launch");
	property p_run_start;
		$rose(busy) |-> $past(ctrl_wr) && $past(wdata[`CTRL_RUN]);
	endproperty
	a_run_start: assert property (p_run_start) else $error("run began without request");
	property p_rep_stop;
		rep_q && $fell(busy) |-> $past(ctrl_wr) && $past(wdata[`CTRL_STOP]);
	endproperty
	a_rep_stop: assert property (p_rep_stop) else $error("repetitive run ended unasked");
	c_rep_stop: cover property (rep_q && $fell(busy));
	c_sig: cover property (intermodule_signal_line);
	c_dly: cover property (seen_hi && $rose(clk_out) && dly_q != 8'h00);
	c_half: cover property (half_q && pat_oe != 32'h0000_0000);
endmodule // pattern_seq_monitor
bind pattern_seq pattern_seq_monitor #(.PER_MAX_CYC(PER_MAX_CYC)) u_pattern_seq_monitor (
	.sys_clk(sys_clk), .rstn(rstn), .vec_ext_clk(vec_ext_clk), .event_in(event_in),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pat_data(pat_data),
	.pat_oe(pat_oe), .clk_out(clk_out), .intermodule_signal_line(intermodule_signal_line),
	.busy(busy));

// ### sut_model.sv
`timescale 1ns/100ps
module sut_model (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clr,
	input wire logic ext_en,
	input wire logic ev,
	input wire logic [31:0] pat_data,
	input wire logic clk_out,
	input wire logic intermodule_signal_line,
	output logic vec_ext_clk,
	output logic event_in
);
	logic [31:0] cap [0:15];
	logic [7:0] n_cap;
	logic [7:0] n_sig;
	logic clk_q;
	// Vectors are taken on the rising clock out edge
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			clk_q <= 1'b0;
			n_cap <= 8'h00;
			n_sig <= 8'h00;
		end else begin
			clk_q <= clk_out;
			if (clr) begin
				n_cap <= 8'h00;
				n_sig <= 8'h00;
			end else begin
				if (clk_out && !clk_q) begin
					cap[n_cap[3:0]] <= pat_data;
					n_cap <= n_cap + 8'h01;
				end
				if (intermodule_signal_line)
					n_sig <= n_sig + 8'h01;
			end
		end
	end
	// 64 ns link clock, below the system rate, still when not enabled
	initial begin
		vec_ext_clk = 1'b0;
		#7;
		forever begin
			#32;
			vec_ext_clk = ext_en ? ~vec_ext_clk : 1'b0;
		end
	end
	always_comb event_in = ev;
endmodule // sut_model

// ### test_vector_pattern_sequencer_tb_top.sv
`timescale 1ns/100ps
`include "pgen_defs.svh"
module test_vector_pattern_sequencer_tb_top;
	logic sys_clk = 1'b0;
	logic rstn;
	logic vec_ext_clk;
	logic event_in;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic [31:0] pat_data;
	logic [31:0] pat_oe;
	logic clk_out;
	logic intermodule_signal_line;
	logic busy;
	logic clr;
	logic ext_en;
	logic ev;
	logic [31:0] v;
	logic [31:0] exp_q[$];
	int failures = 0;
	int n_compared = 0;
	pattern_seq #(.PER_MAX_CYC(24'h00_0064)) u_pattern_seq (
		.sys_clk(sys_clk), .rstn(rstn), .vec_ext_clk(vec_ext_clk), .event_in(event_in),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pat_data(pat_data),
		.pat_oe(pat_oe), .clk_out(clk_out), .intermodule_signal_line(intermodule_signal_line),
		.busy(busy));
	sut_model u_sut_model (
		.sys_clk(sys_clk), .rstn(rstn), .clr(clr), .ext_en(ext_en), .ev(ev),
		.pat_data(pat_data), .clk_out(clk_out),
		.intermodule_signal_line(intermodule_signal_line), .vec_ext_clk(vec_ext_clk),
		.event_in(event_in));
	always #20 sys_clk = ~sys_clk;
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task finish_test;
		if (failures == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task put(input logic [7:0] i, input pgen_pkg::vector_instruction_field_t c, input logic [7:0] o,
		input logic [31:0] d);
		wr_reg(`A_MADDR, {24'h00_0000, i});
		wr_reg(`A_MINST, {20'h0_0000, c, o});
		wr_reg(`A_MDATA, d);
	endtask
	task run(input logic [31:0] ctrl);
		@(posedge sys_clk);
		clr <= 1'b1;
		@(posedge sys_clk);
		clr <= 1'b0;
		wr_reg(`A_CTRL, ctrl);
	endtask
	task wait_idle;
		#1;
		for (int i = 0; i < 3000 && busy !== 1'b0; i++) begin
			@(posedge sys_clk);
			#1;
		end
		check("busy", busy, 32'h0000_0000);
		repeat (8) @(posedge sys_clk);
		#1;
	endtask
	task chk_cap(input logic exact);
		for (int i = 0; i < exp_q.size(); i++)
			check("captured vector", u_sut_model.cap[i], exp_q[i]);
		if (exact)
			check("vector count", u_sut_model.n_cap, 32'(exp_q.size()));
	endtask
	task t_regs;
		rd_reg(`A_PERIOD, v);
		check("period reset", v, 32'h0000_0019);
		rd_reg(`A_CLKDLY, v);
		check("delay reset", v, 32'h0000_0000);
		rd_reg(8'hFC, v);
		check("unmapped read", v, 32'h0000_0000);
		rd_reg(`A_MDATA, v);
		check("data port read", v, 32'h0000_0000);
	endtask
	task t_labels;
		wr_reg(`A_LSEL, 32'h0000_0000);
		wr_reg(`A_LMASK, 32'h0000_00FF);
		wr_reg(`A_LSEL, 32'h0000_0001);
		wr_reg(`A_LMASK, 32'h0000_FF00);
		wr_reg(`A_LSEL, 32'h0000_0002);
		wr_reg(`A_LMASK, 32'h0000_0180);
		rd_reg(`A_LMASK, v);
		check("overlap mask", v, 32'h0000_0000);
		rd_reg(`A_STAT, v);
		check("label error", v[4], 32'h0000_0001);
		wr_reg(`A_CTRL, 32'h0000_0020);
		rd_reg(`A_STAT, v);
		check("label error clear", v[4], 32'h0000_0000);
		wr_reg(`A_LMASK, 32'hFFFF_0000);
		rd_reg(`A_LMASK, v);
		check("label mask", v, 32'hFFFF_0000);
		repeat (2) @(posedge sys_clk);
		#1 check("full enables", pat_oe, 32'hFFFF_FFFF);
		wr_reg(`A_CTRL, 32'h0000_0010);
		repeat (2) @(posedge sys_clk);
		#1 check("half enables", pat_oe, 32'h00FF_00FF);
		wr_reg(`A_CTRL, 32'h0000_0000);
	endtask
	task t_single;
		wr_reg(`A_PERIOD, 32'h0000_0004);
		wr_reg(`A_CLKDLY, 32'h0000_0001);
		wr_reg(`A_LISTLEN, 32'h0000_0301);
		put(8'h01, pgen_pkg::I_NOP, 8'h00, 32'h1234_5678);
		put(8'h02, pgen_pkg::I_NOP, 8'h00, 32'hEEEE_EEEE);
		put(8'h03, pgen_pkg::I_SIGNAL, 8'h00, 32'hA5A5_0001);
		put(8'h04, pgen_pkg::I_REPEAT, 8'h01, 32'h5A5A_0002);
		put(8'h05, pgen_pkg::I_NOP, 8'h00, 32'hFFFF_0003);
		run(32'h0000_0001);
		wait_idle;
		exp_q = '{32'h1234_5678, 32'hA5A5_0001, 32'h5A5A_0002, 32'h5A5A_0002, 32'hFFFF_0003};
		chk_cap(1'b1);
		check("signal pulses", u_sut_model.n_sig, 32'h0000_0001);
		repeat (20) @(posedge sys_clk);
		#1 check("held data", pat_data, 32'hFFFF_0003);
	endtask
	task t_repeat;
		run(32'h0000_0005);
		for (int i = 0; i < 2000 && u_sut_model.n_cap < 8'd9; i++)
			@(posedge sys_clk);
		rd_reg(`A_STAT, v);
		check("first pass flag", v[2], 32'h0000_0000);
		wr_reg(`A_CTRL, 32'h0000_0006);
		wait_idle;
		exp_q = '{32'h1234_5678, 32'hA5A5_0001, 32'h5A5A_0002, 32'h5A5A_0002, 32'hFFFF_0003,
			32'hA5A5_0001, 32'h5A5A_0002, 32'h5A5A_0002, 32'hFFFF_0003};
		chk_cap(1'b0);
	endtask
	task t_macro;
		wr_reg(`A_LISTLEN, 32'h0000_0200);
		put(8'h14, pgen_pkg::I_PARAM, 8'h00, 32'h0000_0000);
		wr_reg(`A_MACDEF, 32'h0000_0114);
		put(8'h02, pgen_pkg::I_MACRO, 8'h00, 32'h0000_00C1);
		put(8'h03, pgen_pkg::I_MACRO, 8'h00, 32'h0000_00C2);
		run(32'h0000_0001);
		wait_idle;
		exp_q = '{32'h0000_00C1, 32'h0000_00C2};
		chk_cap(1'b1);
		put(8'h14, pgen_pkg::I_NOP, 8'h00, 32'h0000_00DD);
		run(32'h0000_0001);
		wait_idle;
		exp_q = '{32'h0000_00DD, 32'h0000_00DD};
		chk_cap(1'b1);
	endtask
	task t_wait;
		put(8'h02, pgen_pkg::I_WAIT, 8'h00, 32'hC3C3_00E1);
		put(8'h03, pgen_pkg::I_NOP, 8'h00, 32'h3C3C_00E2);
		ext_en <= 1'b1;
		run(32'h0000_0009);
		for (int i = 0; i < 500 && u_sut_model.n_cap < 8'd1; i++)
			@(posedge sys_clk);
		repeat (40) @(posedge sys_clk);
		#1 check("vectors while waiting", u_sut_model.n_cap, 32'h0000_0001);
		check("data while waiting", pat_data, 32'hC3C3_00E1);
		check("busy while waiting", busy, 32'h0000_0001);
		rd_reg(`A_STAT, v);
		check("waiting status", v[5], 32'h0000_0001);
		@(posedge sys_clk);
		ev <= 1'b1;
		wait_idle;
		exp_q = '{32'hC3C3_00E1, 32'h3C3C_00E2};
		chk_cap(1'b1);
		ev <= 1'b0;
		ext_en <= 1'b0;
	endtask
	// If-event with event low skips the next entry; break ends the run
	task t_break;
		wr_reg(`A_LISTLEN, 32'h0000_0400);
		put(8'h02, pgen_pkg::I_IFEV, 8'h00, 32'h0000_0011);
		put(8'h03, pgen_pkg::I_NOP, 8'h00, 32'h0000_0022);
		put(8'h04, pgen_pkg::I_BREAK, 8'h00, 32'h0000_0033);
		put(8'h05, pgen_pkg::I_NOP, 8'h00, 32'h0000_0044);
		exp_q = '{32'h0000_0011, 32'h0000_0033};
		wr_reg(`A_PERIOD, 32'h00FF_FFFF);
		run(32'h0000_0001);
		wait_idle;
		chk_cap(1'b1);
		wr_reg(`A_PERIOD, 32'h0000_0000);
		run(32'h0000_0001);
		wait_idle;
		chk_cap(1'b1);
	endtask
	initial begin
		rstn = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		wr = 1'b0;
		rd = 1'b0;
		clr = 1'b0;
		ext_en = 1'b0;
		ev = 1'b0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		t_regs;
		t_labels;
		t_single;
		t_repeat;
		t_macro;
		t_wait;
		t_break;
		finish_test;
	end
	// Whole run needs well under a millisecond
	initial begin
		#2_000_000;
		failures++;
		finish_test;
	end
endmodule // test_vector_pattern_sequencer_tb_top
